/* common/ddc_defines.svh */
// Purpose: Constants for the dual converter serial load front end
// Assumes: Included by its bare name
// Notes: Definitions only
`ifndef DDC_DEFINES_SVH
`define DDC_DEFINES_SVH
`define DDC_WORD_BITS 24
`define DDC_DATA_BITS 16
`define DDC_CH_A_BIT 16
`define DDC_CH_B_BIT 17
`define DDC_RDBK_BIT 20
`define DDC_RDBK_SEL_BIT 21
`define DDC_ZERO_SCALE 16'h0000
`define DDC_MID_SCALE 16'h8000
`define DDC_SYNC_STAGES 3
`define DDC_SETTLE_CYCLES 3'h4
`endif

/* common/ddc_pkg.sv */
// Purpose: Types for the dual converter serial load front end
// Assumes: Nothing beyond the defines header
// Notes: One-hot frame states
`default_nettype none
package ddc_pkg;
    typedef enum logic [2:0]
    {
        DDC_IDLE = 3'h1,
        DDC_SHIFT = 3'h2,
        DDC_FULL = 3'h4
    } ddc_frame_t;
endpackage
`default_nettype wire

/* dv/ddc_host_model.sv */
// Purpose: Host serial controller model for the converter front end
// Assumes: Driven from the bench clock falling edge
// Notes: Serial clock idles high and stands still between frames
`timescale 1ns/10ps
`default_nettype none
module ddc_host_model
(
    input wire logic i_clk,
    input wire logic i_serial_out,
    output logic o_serial_clock,
    output logic o_frame_select_n,
    output logic o_serial_in,
    output logic [23:0] o_rx
);
    // Idle levels at time zero
    initial
    begin
        o_serial_clock = 1'b1;
        o_frame_select_n = 1'b1;
        o_serial_in = 1'b0;
        o_rx = 24'h000000;
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge i_clk);
    endtask

    // One frame of n bits, msb first, 160 ns serial period
    task automatic send(input logic [23:0] w, input int n);
        o_frame_select_n = 1'b0;
        cyc(8);
        for (int k = 0; k < n; k++)
        begin
            o_serial_in = w[23-k];
            cyc(4);
            o_serial_clock = 1'b0;
            cyc(4);
            // Sampled late in the low phase, pin path is slow
            o_rx = {o_rx[22:0], i_serial_out};
            o_serial_clock = 1'b1;
        end
        cyc(8);
        o_frame_select_n = 1'b1;
        o_serial_in = ~o_serial_in; // Released line, no stale value
        cyc(12);
    endtask
endmodule
`default_nettype wire

/* dv/ddc_top_tb.sv */
// Purpose: Self-checking bench for the converter serial load front end
// Assumes: Host model drives the serial pins
// Notes: Buffer full case is not reached with one host
`timescale 1ns/10ps
`default_nettype none
module ddc_top_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ld_n = 1'b1;
    logic rpin_n = 1'b1;
    logic sel = 1'b0;
    logic smode = 1'b0;
    logic sclk, fs_n, sdi, serial_out, rdy;
    logic [15:0] da, db;
    logic [23:0] rx;
    int fail_count = 0;
    int comparisons = 0;

    // 50 MHz clock
    initial
    begin
        forever #10 clk = ~clk;
    end

    ddc_top ddc_top_i (.i_clk(clk), .i_rst_n(rst_n), .i_serial_clock(sclk),
        .i_frame_select_n(fs_n), .i_serial_in(sdi), .i_load_dac_n(ld_n),
        .i_reset_n(rpin_n), .i_reset_level_select(sel), .i_load_sync_mode(smode),
        .o_serial_out(serial_out), .o_word_ready(rdy), .o_dac_a(da), .o_dac_b(db));

    ddc_host_model ddc_host_model_i (.i_clk(clk), .i_serial_out(serial_out),
        .o_serial_clock(sclk), .o_frame_select_n(fs_n), .o_serial_in(sdi), .o_rx(rx));

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic give_verdict();
        $display("counts comparisons=%0d fail_count=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Power-up level follows the select pin
    task automatic t_power(input logic s, input logic [15:0] v);
        sel = s;
        rst_n = 1'b0;
        cyc(4);
        rst_n = 1'b1;
        cyc(12);
        chk(da, v);
        chk(db, v);
        chk({15'h0000, rdy}, 16'h0001);
        $display("done power %0d", s);
    endtask

    // Writes: held-low strobe, then a pulse loading both at once
    task automatic t_write();
        ld_n = 1'b0;
        ddc_host_model_i.send(24'h01A5C3, 24);
        cyc(10);
        chk(da, 16'hA5C3);
        chk(db, 16'h0000);
        ld_n = 1'b1;
        ddc_host_model_i.send(24'h031E77, 24);
        cyc(10);
        chk(da, 16'hA5C3);
        ld_n = 1'b0;
        cyc(6);
        ld_n = 1'b1;
        cyc(4);
        chk(da, 16'h1E77);
        chk(db, 16'h1E77);
        ld_n = 1'b0;
        ddc_host_model_i.send(24'h01FFFF, 23);
        cyc(10);
        chk(da, 16'h1E77);
        smode = 1'b1;
        ddc_host_model_i.send(24'h024321, 24);
        cyc(10);
        chk(db, 16'h4321);
        smode = 1'b0;
        $display("done write");
    endtask

    // Readback of channel A over the next frame
    task automatic t_readback();
        ddc_host_model_i.send(24'h100000, 24);
        ddc_host_model_i.send(24'h000000, 24);
        cyc(10);
        chk(rx[15:0], 16'h1E77);
        chk(da, 16'h1E77);
        $display("done readback");
    endtask

    // Reset pin fall loads scale, low level blocks the strobe
    task automatic t_pin_reset();
        ld_n = 1'b1;
        rpin_n = 1'b0;
        cyc(12);
        chk(da, 16'h0000);
        ddc_host_model_i.send(24'h010F0F, 24);
        ld_n = 1'b0;
        cyc(8);
        chk(da, 16'h0000);
        ld_n = 1'b1;
        rpin_n = 1'b1;
        cyc(4);
        $display("done pin reset");
    endtask

    initial
    begin
        t_power(1'b1, 16'h8000);
        t_power(1'b0, 16'h0000);
        t_write();
        t_readback();
        t_pin_reset();
        give_verdict();
    end

    // About 1650 cycles expected; cut off well beyond
    initial
    begin
        #400000;
        fail_count++;
        give_verdict();
    end
endmodule
`default_nettype wire

/* logic/ddc_top.sv */
// Purpose: Serial load front end of a dual voltage output converter
// Assumes: Pins are asynchronous to i_clk; serial clock well below i_clk/2
// Notes: Serial clock is oversampled, so the full pin rate is not reached here
// Operation
// - Shift serial_in on each serial clock fall
// - Take exactly 24 bits after frame goes low
// - Input shift register is 24 bits wide
// - serial_out changes on serial clock rise
// - serial_out gives daisy chain or readback data
// - Low load_dac_n copies input to DAC registers
// - Load strobe has asynchronous and synchronous modes
// - Reset pin acts on its falling edge
// - Reset low blocks every load strobe
// - Reset loads zero or midscale per select
// - Select low powers up at zero scale
// - Select high powers up at midscale
`timescale 1ns/10ps
`default_nettype none
`include "ddc_defines.svh"
module ddc_top
    import ddc_pkg::*;
#(
    parameter int DEPTH = 2
)
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_serial_clock,
    input wire logic i_frame_select_n,
    input wire logic i_serial_in,
    input wire logic i_load_dac_n,
    input wire logic i_reset_n,
    input wire logic i_reset_level_select,
    input wire logic i_load_sync_mode,
    output logic o_serial_out,
    output logic o_word_ready,
    output logic [`DDC_DATA_BITS-1:0] o_dac_a,
    output logic [`DDC_DATA_BITS-1:0] o_dac_b
);
    localparam int SCK = 0;
    localparam int FRM = 1;
    localparam int DIN = 2;
    localparam int LDN = 3;
    localparam int RSN = 4;
    localparam int RSL = 5;
    localparam int NW = `DDC_WORD_BITS;
    localparam int ND = `DDC_DATA_BITS;

    typedef struct packed
    {
        logic [5:0][`DDC_SYNC_STAGES-1:0] sy;
        logic [5:0] lv;
        logic [5:0] lv_p;
        ddc_frame_t st;
        logic [NW-1:0] shift;
        logic [4:0] cnt;
        logic serial_out;
        logic [1:0][NW-1:0] fifo;
        logic wp;
        logic rp;
        logic [1:0] fill;
        logic [ND-1:0] in_a;
        logic [ND-1:0] in_b;
        logic [ND-1:0] dac_a;
        logic [ND-1:0] dac_b;
        logic [1:0] pend;
        logic [2:0] settle;
        logic ready;
    } ddc_state_t;

    ddc_state_t q;
    ddc_state_t n;
    logic [5:0] pins;
    logic sck_fall;
    logic sck_rise;
    logic rst_fall;
    logic in_reset;
    logic push;
    logic pop;
    logic [NW-1:0] head;
    logic [ND-1:0] scale;

    assign pins = {i_reset_level_select, i_reset_n, i_load_dac_n,
                   i_serial_in, i_frame_select_n, i_serial_clock};
    // Edges come from the filtered levels, never from the first stage
    assign sck_fall = q.lv_p[SCK] & ~q.lv[SCK];
    assign sck_rise = ~q.lv_p[SCK] & q.lv[SCK];
    assign rst_fall = q.lv_p[RSN] & ~q.lv[RSN];
    assign in_reset = ~q.lv[RSN] | ~q.ready;
    assign head = q.fifo[q.rp];
    assign scale = q.lv[RSL] ? `DDC_MID_SCALE : `DDC_ZERO_SCALE;
    // Buffer full drops the finished frame's word; draining stalls while reset is low
    assign push = (q.st == DDC_FULL) && q.lv[FRM] && !q.shift[`DDC_RDBK_BIT]
                  && (q.fill != 2'(DEPTH));
    assign pop = (q.fill != 2'h0) && !in_reset;

    // Next state of the whole block
    always_comb
    begin
        n = q;
        n.lv_p = q.lv;
        for (int i = 0; i < 6; i++)
        begin
            n.sy[i] = {q.sy[i][1:0], pins[i]};
            if (q.sy[i][1] == q.sy[i][2])
            begin
                n.lv[i] = q.sy[i][2];
            end
        end
        // Output moves only on a rising serial clock edge
        if (sck_rise)
        begin
            n.serial_out = q.shift[NW-1];
        end
        case (q.st)
            DDC_IDLE:
            begin
                if (!q.lv[FRM])
                begin
                    n.st = DDC_SHIFT;
                    n.cnt = 5'h00;
                end
            end
            DDC_SHIFT:
            begin
                if (q.lv[FRM])
                begin
                    n.st = DDC_IDLE;
                end
                else if (sck_fall)
                begin
                    n.shift = {q.shift[NW-2:0], q.lv[DIN]};
                    n.cnt = q.cnt + 5'h01;
                    if (q.cnt == 5'(NW - 1))
                    begin
                        n.st = DDC_FULL;
                    end
                end
            end
            DDC_FULL:
            begin
                // Extra edges after the 24th are ignored
                if (q.lv[FRM])
                begin
                    n.st = DDC_IDLE;
                    if (q.shift[`DDC_RDBK_BIT])
                    begin
                        n.shift = {8'h00, q.shift[`DDC_RDBK_SEL_BIT] ? q.in_b : q.in_a};
                    end
                end
            end
            default:
            begin
                n.st = DDC_IDLE;
            end
        endcase
        // Two-entry word buffer between frame and input registers
        if (push)
        begin
            n.fifo[q.wp] = q.shift;
            n.wp = ~q.wp;
        end
        if (pop)
        begin
            n.rp = ~q.rp;
            if (head[`DDC_CH_A_BIT])
            begin
                n.in_a = head[ND-1:0];
            end
            if (head[`DDC_CH_B_BIT])
            begin
                n.in_b = head[ND-1:0];
            end
            n.pend = q.pend | {head[`DDC_CH_B_BIT], head[`DDC_CH_A_BIT]};
        end
        n.fill = q.fill + 2'(push) - 2'(pop);
        // Load strobe, level sensed so a tied-low strobe still updates
        if (!in_reset && !q.lv[LDN])
        begin
            if (!i_load_sync_mode)
            begin
                if (q.pend[0]) n.dac_a = q.in_a;
                if (q.pend[1]) n.dac_b = q.in_b;
                // A word landing in this cycle stays pending, the set wins
                n.pend = (n.pend & ~q.pend)
                         | (pop ? {head[`DDC_CH_B_BIT], head[`DDC_CH_A_BIT]} : 2'h0);
            end
            else if (pop)
            begin
                if (head[`DDC_CH_A_BIT]) n.dac_a = head[ND-1:0];
                if (head[`DDC_CH_B_BIT]) n.dac_b = head[ND-1:0];
                n.pend = q.pend & ~{head[`DDC_CH_B_BIT], head[`DDC_CH_A_BIT]};
            end
        end
        // Power-up load waits until the filtered select level is registered
        if (!q.ready)
        begin
            n.settle = q.settle + 3'h1;
            if (q.settle == `DDC_SETTLE_CYCLES)
            begin
                n.ready = 1'b1;
                n.in_a = scale;
                n.in_b = scale;
                n.dac_a = scale;
                n.dac_b = scale;
            end
        end
        if (rst_fall)
        begin
            n.in_a = scale;
            n.in_b = scale;
            n.dac_a = scale;
            n.dac_b = scale;
            n.pend = 2'h0;
        end
    end

    // Register the state; reset to constants only
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            q <= '0;
            q.sy <= {6{3'h7}};
            q.lv <= 6'h1F;
            q.lv_p <= 6'h1F;
            q.st <= DDC_IDLE;
        end
        else
        begin
            q <= n;
        end
    end

    assign o_serial_out = q.serial_out;
    assign o_word_ready = (q.fill != 2'(DEPTH));
    assign o_dac_a = q.dac_a;
    assign o_dac_b = q.dac_b;

    sequence frame_done_s;
        q.st == DDC_FULL && q.lv[FRM];
    endsequence

    sequence fall_s;
        sck_fall && q.st == DDC_SHIFT && !q.lv[FRM];
    endsequence

    shift_on_fall_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        fall_s |=> q.shift[0] == $past(q.lv[DIN]))
        else $error("shift register missed the sampled bit");
    count_24_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        q.st == DDC_FULL |-> q.cnt == 5'h18)
        else $error("frame full without 24 bits");
    width_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        q.st == DDC_FULL && !q.lv[FRM] |=> $stable(q.shift))
        else $error("shift register moved after 24 bits");
    sdo_rise_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !sck_rise |=> $stable(o_serial_out))
        else $error("serial out changed off a rising edge");
    sdo_msb_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        sck_rise |=> o_serial_out == $past(q.shift[NW-1]))
        else $error("serial out not the shifted msb");
    load_dac_n_update_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !in_reset && !q.lv[LDN] && !i_load_sync_mode && q.pend[0] && !rst_fall
        |=> o_dac_a == $past(q.in_a))
        else $error("load strobe did not move channel a");
    reset_block_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        q.ready && !q.lv[RSN] && !rst_fall |=> $stable(o_dac_a) && $stable(o_dac_b))
        else $error("dac register changed while reset low");
    reset_scale_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        rst_fall |=> o_dac_a == $past(scale) && o_dac_b == $past(scale))
        else $error("reset loaded the wrong scale");
    frame_abort_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        q.st == DDC_SHIFT && q.lv[FRM]
        |=> q.st == DDC_IDLE && q.fill + 2'($past(pop)) == $past(q.fill))
        else $error("partial frame reached the buffer");
    push_once_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        frame_done_s && !q.shift[`DDC_RDBK_BIT] && q.fill != 2'(DEPTH)
        |=> q.fifo[$past(q.wp)] == $past(q.shift) && !push)
        else $error("word pushed twice");
endmodule
`default_nettype wire
